/* hdl/pioa_port_io.sv */
// Port pin configuration, crossbar assignment and pin event capture
//
// Chosen here: the address map and the Wishbone register port.
`timescale 1ns/1ps
`include "pioa_defines.svh"

// Contract
// - Pin state is always readable through the pin read register; port 4 pins are read instead at event mask register bits 31:24.
// - After reset pads float with pull-ups until crossbar is enabled.
// - Analog pin: pull-up, driver and receiver all off.
// - Analog pins read back as 0.
// - Push-pull pin drives pad to its output value.
// - Open-drain pin never drives high, pulls low on 0.
// - Pull-up on released digital pins; off if driving low or disabled.
// - Digital pin reads the sensed pad level.
// - Port 4 pins are digital only.
// - Analog pins should be skipped; crossbar never uses skipped pins, except fixed serial and CAN pins 4-7.
// - Serial on bits 4,5 and CAN on bits 6,7 of port 0 always.
// - Crossbar assigns only pins whose skip bit is 0; fixed serial and CAN pins 4-7 are taken whatever their skip bits.
// - Port 4 has no skip bits.
// - Digital pin transitions raise event, skipped or assigned.
// - Analog pins produce no events.
// - Each enabled resource takes lowest free unskipped pin in order.
// - Crossbar disabled keeps all output drivers off.
// - Management bus pins are always open-drain.
// - Crossbar enabled only by the enable bit in route register 2.
module pioa_port_io
    import pioa_pkg::*;
#(
    parameter int NPINS = 40,
    parameter int NRES  = `PIOA_R1_NUM
) (
    input  wire logic            clk_i,
    input  wire logic            nrst_i,
    input  wire logic            ce_i,
    input  wire pioa_wb_req_type wb_req_i,
    output logic [31:0]          wb_dat_o,
    output logic                 wb_ack_o,
    input  wire logic [39:0]     pad_i,
    input  wire logic [1:0]      serial_tx_i,
    input  wire logic [1:0]      can_tx_i,
    input  wire logic [1:0]      mgmt_tx_i,
    input  wire logic [NRES-1:0] res_tx_i,
    output pioa_pad_type         pad_o,
    output logic [39:0]          pad_rx_o,
    output logic                 event_o
);

    if (NPINS != 40 || NRES < 1 || NRES > 8) begin : g_bad_param
        $error("pioa_port_io: unsupported parameters");
    end

    // ==========================================================
    // Registers
    logic [31:0] in_mode_lo;
    logic [39:0] out_mode;
    logic [31:0] skip;
    logic [39:0] latch;
    logic [7:0]  route0;
    logic [7:0]  route1;
    logic [7:0]  route2;
    logic [39:0] evt_mask;
    logic [39:0] evt_flag;
    logic [39:0] sync1;
    logic [39:0] sync2;
    logic [39:0] sync3;
    logic [39:0] in_mode;
    logic [39:0] next_assigned;
    logic [39:0] next_o;
    logic [39:0] next_oe;
    logic [39:0] next_pu;
    logic [39:0] pin_read;
    logic [39:0] is_mgmt;
    logic [39:0] evt_hit;
    logic        xbar_en;
    logic        wr;
    logic        rd_idx_ok;
    logic [31:0] next_rdata;

    // Port 4 always digital
    assign in_mode = {8'hFF, in_mode_lo};
    assign xbar_en = route2[`PIOA_R2_XBAR_EN];
    assign wr = wb_req_i.cyc & wb_req_i.stb & wb_req_i.we & ~wb_ack_o;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // ==========================================================
    // Configuration writes
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            in_mode_lo <= `PIOA_IN_MODE_RST;
            out_mode   <= 40'h00_0000_0000;
            skip       <= 32'h0000_0000;
            latch      <= {8'hFF, `PIOA_LATCH_RST};
            route0     <= 8'h00;
            route1     <= 8'h00;
            route2     <= 8'h00;
            evt_mask   <= 40'h00_0000_0000;
        end else if (ce_i && wr) begin
            case (wb_req_i.adr)
                `PIOA_IDX_IN_MODE: begin
                    in_mode_lo <= merge(in_mode_lo, wb_req_i.dat,
                                        wb_req_i.sel);
                end
                `PIOA_IDX_OUT_MODE: begin
                    out_mode[31:0] <= merge(out_mode[31:0], wb_req_i.dat,
                                            wb_req_i.sel);
                end
                `PIOA_IDX_SKIP: begin
                    skip <= merge(skip, wb_req_i.dat, wb_req_i.sel);
                end
                `PIOA_IDX_LATCH: begin
                    latch[31:0] <= merge(latch[31:0], wb_req_i.dat,
                                         wb_req_i.sel);
                end
                `PIOA_IDX_ROUTE0: begin
                    if (wb_req_i.sel[0]) route0 <= wb_req_i.dat[7:0];
                    if (wb_req_i.sel[1]) out_mode[39:32] <= wb_req_i.dat[15:8];
                    if (wb_req_i.sel[2]) latch[39:32] <= wb_req_i.dat[23:16];
                end
                `PIOA_IDX_ROUTE1: begin
                    if (wb_req_i.sel[0]) route1 <= wb_req_i.dat[7:0];
                end
                `PIOA_IDX_ROUTE2: begin
                    if (wb_req_i.sel[0]) route2 <= wb_req_i.dat[7:0];
                end
                `PIOA_IDX_EVT_MASK: begin
                    evt_mask[31:0] <= merge(evt_mask[31:0], wb_req_i.dat,
                                            wb_req_i.sel);
                    if (wb_req_i.sel[0] && wb_req_i.dat[0]) begin
                        evt_mask[39:32] <= evt_mask[39:32];
                    end
                end
                `PIOA_IDX_ASSIGNED: begin
                    if (wb_req_i.sel[0]) evt_mask[39:32] <= wb_req_i.dat[7:0];
                end
                default: begin
                end
            endcase
        end
    end

    // ==========================================================
    // Input synchroniser and receiver gating
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            sync1 <= 40'h00_0000_0000;
            sync2 <= 40'h00_0000_0000;
            sync3 <= 40'h00_0000_0000;
        end else if (ce_i) begin
            sync1 <= pad_i;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    assign pin_read = sync2 & in_mode;

    // ==========================================================
    // Priority crossbar
    always_comb begin
        logic [39:0] taken;
        logic [39:0] avail;
        int          r;
        avail = 40'h00_0000_0000;
        r = 0;
        taken = 40'h00_0000_0000;
        next_assigned = 40'h00_0000_0000;
        next_o = latch;
        is_mgmt = 40'h00_0000_0000;
        if (route0[`PIOA_R0_SERIAL]) begin
            taken[`PIOA_SERIAL_TX] = 1'b1;
            taken[`PIOA_SERIAL_RX] = 1'b1;
            next_o[`PIOA_SERIAL_TX] = serial_tx_i[0];
            next_o[`PIOA_SERIAL_RX] = serial_tx_i[1];
        end
        if (route0[`PIOA_R0_CAN]) begin
            taken[`PIOA_CAN_TX] = 1'b1;
            taken[`PIOA_CAN_RX] = 1'b1;
            next_o[`PIOA_CAN_TX] = can_tx_i[0];
            next_o[`PIOA_CAN_RX] = can_tx_i[1];
        end
        // Skipped pins never offered; port 4 has none
        avail = ~taken & ~{8'h00, skip};
        for (int k = 0; k < 2; k++) begin
            r = 0;
            for (int p = 39; p >= 0; p--) begin
                if (avail[p]) r = p;
            end
            if (route0[`PIOA_R0_MGMT] && avail[r]) begin
                avail[r] = 1'b0;
                taken[r] = 1'b1;
                is_mgmt[r] = 1'b1;
                next_o[r] = mgmt_tx_i[k];
            end
        end
        for (int k = 0; k < NRES; k++) begin
            r = 0;
            for (int p = 39; p >= 0; p--) begin
                if (avail[p]) r = p;
            end
            if (route1[k] && avail[r]) begin
                avail[r] = 1'b0;
                taken[r] = 1'b1;
                next_o[r] = res_tx_i[k];
            end
        end
        next_assigned = taken;
    end

    // ==========================================================
    // Pad cell drive and pull-up
    genvar g;
    generate
        for (g = 0; g < 40; g++) begin : g_cell
            logic pp;
            assign pp = out_mode[g] & ~is_mgmt[g];
            // Push-pull drives both levels, open-drain only low
            assign next_oe[g] = xbar_en & in_mode[g]
                              & (pp | ~next_o[g]);
            // Pull-up: reset state, or released digital pin
            assign next_pu[g] = ~route2[`PIOA_R2_PUD] & in_mode[g]
                              & (~xbar_en | ~next_oe[g]);
        end
    endgenerate

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            pad_o.o  <= 40'h00_0000_0000;
            pad_o.oe <= 40'h00_0000_0000;
            pad_o.pu <= 40'hFF_FFFF_FFFF;
            pad_rx_o <= 40'h00_0000_0000;
        end else if (ce_i) begin
            pad_o.o  <= next_o & next_oe;
            pad_o.oe <= next_oe;
            pad_o.pu <= next_pu;
            pad_rx_o <= pin_read;
        end
    end

    // ==========================================================
    // Pin event capture, set wins over clear
    assign evt_hit = (sync2 ^ sync3) & in_mode;

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            evt_flag <= 40'h00_0000_0000;
            event_o  <= 1'b0;
        end else if (ce_i) begin
            if (wr && wb_req_i.adr == `PIOA_IDX_EVT_FLAG) begin
                evt_flag <= (evt_flag & ~{8'h00, wb_req_i.dat}) | evt_hit;
            end else begin
                evt_flag <= evt_flag | evt_hit;
            end
            event_o <= |(evt_hit & evt_mask);
        end
    end

    // ==========================================================
    // Wishbone read and acknowledge
    assign rd_idx_ok = (wb_req_i.adr <= `PIOA_IDX_ASSIGNED);

    always_comb begin
        case (wb_req_i.adr)
            `PIOA_IDX_IN_MODE:  next_rdata = in_mode_lo;
            `PIOA_IDX_OUT_MODE: next_rdata = out_mode[31:0];
            `PIOA_IDX_SKIP:     next_rdata = skip;
            `PIOA_IDX_LATCH:    next_rdata = latch[31:0];
            `PIOA_IDX_ROUTE0:   next_rdata = {8'h00, latch[39:32],
                                              out_mode[39:32], route0};
            `PIOA_IDX_ROUTE1:   next_rdata = {24'h000000, route1};
            `PIOA_IDX_ROUTE2:   next_rdata = {24'h000000, route2};
            `PIOA_IDX_PIN_READ: next_rdata = pin_read[31:0];
            `PIOA_IDX_EVT_MASK: next_rdata = {pin_read[39:32], 24'h000000};
            `PIOA_IDX_EVT_FLAG: next_rdata = evt_flag[31:0];
            `PIOA_IDX_ASSIGNED: next_rdata = {evt_flag[39:32], 8'h00,
                                              next_assigned[39:32],
                                              evt_mask[39:32]};
            default:            next_rdata = 32'h0000_0000;
        endcase
        if (!rd_idx_ok) next_rdata = 32'h0000_0000;
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else if (ce_i) begin
            wb_ack_o <= wb_req_i.cyc & wb_req_i.stb & ~wb_ack_o;
            wb_dat_o <= next_rdata;
        end
    end

    // ==========================================================
    // Checks
    a_analog_no_drive: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        ce_i && !in_mode[9] |=> !pad_o.oe[9] && !pad_o.pu[9])
        else $error("analog pin driven or pulled");
    a_analog_reads_zero: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        ce_i && !in_mode[9] |=> !pad_rx_o[9])
        else $error("analog pin read nonzero");
    a_open_drain_high: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        (pad_o.oe & pad_o.o & ($past(is_mgmt) | ~$past(out_mode)))
            == 40'h00_0000_0000)
        else $error("open-drain pin driven high");
    a_xbar_off_quiet: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        ce_i && !xbar_en |=> pad_o.oe == 40'h00_0000_0000)
        else $error("driver on while crossbar off");
    a_pull_low_off: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        (pad_o.oe & ~pad_o.o & pad_o.pu) == 40'h00_0000_0000)
        else $error("pull-up on while driving low");
    a_serial_fixed: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        ce_i && xbar_en && route0[`PIOA_R0_SERIAL]
            && (in_mode[5:4] & out_mode[5:4]) == 2'b11
        |=> pad_o.oe[5:4] == 2'b11 && pad_o.o[5:4] == $past(serial_tx_i))
        else $error("serial pins misplaced");
    a_skip_honoured: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        (next_assigned[31:0] & skip & ~32'h0000_00F0) == 32'h0000_0000)
        else $error("skipped pin assigned");
    a_event_analog: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        ce_i && !in_mode[9] |=> !$rose(evt_flag[9]))
        else $error("event on analog pin");
    a_mode_latency: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        ce_i ##1 ce_i |-> pad_o.oe == $past(next_oe))
        else $error("config not applied next edge");

endmodule // pioa_port_io

/* pkg/pioa_defines.svh */
// Register offsets, field positions and reset values of the port block
`ifndef PIOA_DEFINES_SVH
`define PIOA_DEFINES_SVH

// Register word offsets (byte address = 4 * index)
`define PIOA_IDX_IN_MODE   4'h0
`define PIOA_IDX_OUT_MODE  4'h1
`define PIOA_IDX_SKIP      4'h2
`define PIOA_IDX_LATCH     4'h3
`define PIOA_IDX_ROUTE0    4'h4
`define PIOA_IDX_ROUTE1    4'h5
`define PIOA_IDX_ROUTE2    4'h6
`define PIOA_IDX_PIN_READ  4'h7
`define PIOA_IDX_EVT_MASK  4'h8
`define PIOA_IDX_EVT_FLAG  4'h9
`define PIOA_IDX_ASSIGNED  4'hA

// Route register 0 fields
`define PIOA_R0_SERIAL     0
`define PIOA_R0_CAN        1
// Route register 1: one enable bit per single-pin resource
`define PIOA_R1_NUM        8
// Route register 2 fields
`define PIOA_R2_PUD        7
`define PIOA_R2_XBAR_EN    6
// Management bus pair enable within route register 0
`define PIOA_R0_MGMT       3

// Fixed pin placements
`define PIOA_SERIAL_TX     4
`define PIOA_SERIAL_RX     5
`define PIOA_CAN_TX        6
`define PIOA_CAN_RX        7

// Reset values
`define PIOA_IN_MODE_RST   32'hFFFFFFFF
`define PIOA_LATCH_RST     32'hFFFFFFFF

`endif

/* pkg/pioa_pkg.sv */
// Types shared by the port block
package pioa_pkg;
    typedef struct packed {
        logic [31:0] dat;
        logic [5:2]  adr;
        logic [3:0]  sel;
        logic        we;
        logic        stb;
        logic        cyc;
    } pioa_wb_req_type;

    typedef struct packed {
        logic [39:0] o;
        logic [39:0] oe;
        logic [39:0] pu;
    } pioa_pad_type;
endpackage

/* tb/pioa_board.sv */
// Board model: resolves every pad level from device, board and pull-up
`timescale 1ns/1ps

module pioa_board
    import pioa_pkg::*;
(
    input  wire logic         clk_i,
    input  wire pioa_pad_type pad_o_i,
    input  wire logic [39:0]  ext_val_i,
    input  wire logic [39:0]  ext_oe_i,
    output logic [39:0]       pad_i_o
);
    logic [39:0] flt = 40'h00000000;

    // =========================================
    // Undriven pad without pull-up wanders
    always @(posedge clk_i) begin
        flt <= ~flt;
    end

    always_comb begin
        for (int p = 0; p < 40; p++) begin
            if (pad_o_i.oe[p])
                pad_i_o[p] = pad_o_i.o[p];
            else if (ext_oe_i[p])
                pad_i_o[p] = ext_val_i[p];
            else if (pad_o_i.pu[p])
                pad_i_o[p] = 1'b1;
            else
                pad_i_o[p] = flt[p];
        end
    end
endmodule // pioa_board

/* tb/tb_port_io_pin_assignment.sv */
// Self-checking bench of the port pin block
`timescale 1ns/1ps

module tb_port_io_pin_assignment;
    import pioa_pkg::*;

    logic            clk_i = 1'b0;
    logic            nrst_i = 1'b0;
    pioa_wb_req_type wb_req = '0;
    logic [31:0]     wb_dat_o;
    logic            wb_ack_o;
    logic [39:0]     pad_i;
    logic [1:0]      serial_tx = 2'h0;
    logic [1:0]      can_tx = 2'h0;
    logic            ce = 1'b1;
    logic [1:0]      mgmt_tx = 2'h0;
    logic [7:0]      res_tx = 8'h00;
    pioa_pad_type    pad_o;
    logic [39:0]     pad_rx_o;
    logic            event_o;
    logic [39:0]     ext_val = 40'h0000000000;
    logic [39:0]     ext_oe = 40'h0000000000;
    int              n_mismatch = 0;
    int              cmp_count = 0;
    int              seed = 32'h34c536a9;
    logic [32:0]     note_q[$];
    logic [31:0]     r;
    logic [31:0]     lat;

    always #5 clk_i = ~clk_i;

    pioa_port_io i_pioa_port_io (
        .clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce), .wb_req_i(wb_req),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pad_i(pad_i),
        .serial_tx_i(serial_tx), .can_tx_i(can_tx), .mgmt_tx_i(mgmt_tx),
        .res_tx_i(res_tx), .pad_o(pad_o), .pad_rx_o(pad_rx_o),
        .event_o(event_o));

    pioa_board i_pioa_board (
        .clk_i(clk_i), .pad_o_i(pad_o), .ext_val_i(ext_val),
        .ext_oe_i(ext_oe), .pad_i_o(pad_i));

    // =========================================
    // Compare, report, finish
    task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("Mismatches %0d, comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // =========================================
    // Bus cycle; the expectation is queued for the monitor
    task automatic acc(input logic we, input logic [3:0] idx,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_req <= '{dat: we ? d : 32'h0, adr: idx, sel: 4'hF, we: we,
                    stb: 1'b1, cyc: 1'b1};
        note_q.push_back({~we, d});
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (n >= 20) begin
            n_mismatch++;
            end_sim();
        end
        wb_req.cyc <= 1'b0;
        wb_req.stb <= 1'b0;
        @(posedge clk_i);
    endtask

    // Read results compared when acknowledged
    always @(posedge clk_i) begin
        if (nrst_i && wb_ack_o === 1'b1) begin
            if (note_q.size() == 0)
                chk(40'h1, 40'h0);
            else if (note_q[0][32])
                chk({8'h00, wb_dat_o}, {8'h00, note_q[0][31:0]});
            if (note_q.size() != 0)
                void'(note_q.pop_front());
        end
    end

    task automatic wait_evt(input logic want);
        logic seen;
        seen = 1'b0;
        repeat (10) begin
            @(posedge clk_i);
            seen = seen | (event_o === 1'b1);
        end
        chk({39'h0, seen}, {39'h0, want});
    endtask

    // =========================================
    // Main sequence
    initial begin
        repeat (12) @(posedge clk_i);
        nrst_i <= 1'b1;
        @(posedge clk_i);
        chk(pad_o.oe, 40'h0);
        chk(pad_o.pu, 40'hFFFFFFFFFF);
        r = $random(seed);
        ext_oe <= 40'hFFFFFFFFFF;
        ext_val <= {8'h5A, r};
        repeat (5) @(posedge clk_i);
        acc(0, 4'h7, r);
        acc(1, 4'h0, 32'hFFFF00FF);
        acc(0, 4'h0, 32'hFFFF00FF);
        chk(pad_o.pu[15:8], 40'h0);
        repeat (4) @(posedge clk_i);
        chk(pad_rx_o[15:8], 40'h0);
        acc(0, 4'h7, r & 32'hFFFF00FF);
        acc(0, 4'hB, 32'h0);
        ext_oe <= 40'h0000000000;
        lat = $random(seed);
        acc(1, 4'h3, lat);
        acc(1, 4'h1, 32'hFFFFFFFF);
        chk(pad_o.oe, 40'h0);
        acc(1, 4'h6, 32'h00000040);
        chk(pad_o.oe[31:0], 40'hFFFF00FF);
        chk(pad_o.o[31:0] & 32'hFFFF00FF, lat & 32'hFFFF00FF);
        repeat (4) @(posedge clk_i);
        acc(0, 4'h7, lat & 32'hFFFF00FF);
        acc(1, 4'h1, 32'h0);
        chk(pad_o.oe[31:0], ~lat & 32'hFFFF00FF);
        chk(pad_o.pu[31:0], lat & 32'hFFFF00FF);
        acc(1, 4'h6, 32'h000000C0);
        chk(pad_o.pu[31:0], 40'h0);
        // Serial fixed pins, management pair after skipped pin 0
        acc(1, 4'h6, 32'h00000040);
        acc(1, 4'h2, 32'h00000001);
        acc(1, 4'h1, 32'hFFFFFFFF);
        mgmt_tx <= 2'b01;
        serial_tx <= r[1:0];
        can_tx <= ~r[1:0];
        res_tx <= r[9:2];
        acc(1, 4'h4, 32'h0000000B);
        acc(1, 4'h5, 32'h00000001);
        chk(pad_o.oe[2:1], 40'h2);
        chk(pad_o.oe[0], 40'h1);
        chk({pad_o.oe[7:4], pad_o.o[7:4]},
            {32'h0, 4'hF, ~r[1:0], r[1:0]});
        chk({pad_o.oe[3], pad_o.o[3]}, {38'h0, 1'b1, r[2]});
        // Events: driven pin 16 fires, analog pin 9 stays quiet
        acc(1, 4'h6, 32'h00000000);
        ext_oe <= 40'h0000010200;
        ext_val <= 40'h0;
        repeat (8) @(posedge clk_i);
        acc(1, 4'h8, 32'h00010200);
        acc(1, 4'h9, 32'hFFFFFFFF);
        acc(0, 4'h9, 32'h00000000);
        ext_val[16] <= 1'b1;
        wait_evt(1'b1);
        acc(0, 4'h9, 32'h00010000);
        ext_val[9] <= 1'b1;
        wait_evt(1'b0);
        acc(0, 4'h9, 32'h00010000);
        // Clock enable low freezes the receiver path
        ce <= 1'b0;
        ext_val[16] <= 1'b0;
        repeat (6) @(posedge clk_i);
        chk(pad_rx_o[16], 40'h1);
        ce <= 1'b1;
        repeat (5) @(posedge clk_i);
        chk(pad_rx_o[16], 40'h0);
        end_sim();
    end
endmodule // tb_port_io_pin_assignment
